//--- pkg/tws_pkg.sv
// Purpose: Shared constants for the two-wire configuration slave and its master.
// Assumes: 200 MHz system clock on both ends.
// Notes: Register indices, field positions, reset values and timing counts.
// Summary of operation
// (R01) Slave answers only address 1000100 plus direction
// (R02) Order: START, address, index, data, STOP
// (R03) One data byte per transfer, no increment
// (R04) START is data falling while clock high
// (R05) STOP is data rising while clock high
// (R06) Repeated START restarts the address phase
// (R07) Receiver holds data low through acknowledge
// (R08) Unmatched address leaves acknowledge slot released
// (R09) Refused byte gets no acknowledge, master stops
// (R10) Slave never drives clock nor starts transfers
// (R11) Registers writable, control and status readable
// (R12) Control bit 1 turns offset cancellation off
// (R13) Threshold code zero disables threshold adjust
// (R14) Receiver settings apply only with select set
// (R15) Software writes 0x81 or 0x85 for optimization
// (R16) Three-bit swing code, default 010
// (R17) De-emphasis code zero to 8dB, 1dB steps
// (R18) Control bit 4 inverts data output polarity
// (R19) Control bit 2 selects high loss range
// (R20) Level select bit picks programmed loss level
// (R21) Rising and falling loss masks, enable bit 7
// (R22) Each mask count adds 32 microseconds
// (R23) Read: index write, repeated START, read, NACK
// (R24) Masked flag holds old level, then follows
package tws_pkg;
	localparam logic [6:0] SLAVE_ADDR = 7'h44;
	localparam int CLK_MHZ = 200;
	// Mask step and the master's quarter bit period
	localparam int MASK_STEP_US = 32;
	localparam int MASK_STEP_CYC = MASK_STEP_US * CLK_MHZ;
	localparam int QTR_NS = 700;
	localparam int QTR_CYC = (QTR_NS * CLK_MHZ + 999) / 1000;
	// Register indices
	localparam logic [7:0] IDX_CTRL = 8'h00;
	localparam logic [7:0] IDX_THRESH = 8'h01;
	localparam logic [7:0] IDX_RANGE_DE = 8'h02;
	localparam logic [7:0] IDX_SWING = 8'h03;
	localparam logic [7:0] IDX_RECEIVER_EQUALIZE_CODE = 8'h07;
	localparam logic [7:0] IDX_LEVEL = 8'h0b;
	localparam logic [7:0] IDX_FALL_MASK = 8'h0c;
	localparam logic [7:0] IDX_RISE_MASK = 8'h0d;
	localparam logic [7:0] IDX_LEVEL_RO = 8'h0f;
	// Field positions
	localparam int BIT_OC_OFF = 1;
	localparam int BIT_LOST_RANGE = 2;
	localparam int BIT_INVERT = 4;
	localparam int BIT_SELECT = 7;
	localparam int BIT_BIAS = 0;
	localparam int MAX_DEEMPH = 8;
	// Values after reset
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [7:0] SWING_RST = 8'h02;
	localparam logic [1:0] RXEQ_DEFAULT = 2'h0;
	localparam logic [6:0] LEVEL_DEFAULT = 7'h40;
	localparam logic FLAG_RST = 1'b1;
	// Master register offsets
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
endpackage : tws_pkg

//--- pkg/tws_if.sv
// Purpose: Two-wire bus between master and slave, open drain with pull-ups.
// Assumes: Every driver only pulls low; released lines read high.
// Notes: Wire levels are resolved here from the output enables.
`timescale 1ns/100ps
interface tws_if;
	logic m_scl_o;
	logic m_scl_oe;
	logic m_sda_o;
	logic m_sda_oe;
	logic d_sda_o;
	logic d_sda_oe;
	logic scl;
	logic sda;
	// Pull-up wins unless some end drives low
	assign scl = ~(m_scl_oe & ~m_scl_o);
	assign sda = ~((m_sda_oe & ~m_sda_o) | (d_sda_oe & ~d_sda_o));
	modport dev (input scl, input sda, output d_sda_o, output d_sda_oe);
	modport host (input scl, input sda, output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe);
endinterface : tws_if

//--- hdl/tws_mask.sv
// Purpose: Edge masking timer for the signal-lost flag.
// Assumes: raw is already synchronised to clk.
// Notes: A count of zero passes the change at once.
`timescale 1ns/100ps
module tws_mask import tws_pkg::*; #(parameter int STEP_CYCLES = MASK_STEP_CYC) (
	input wire logic clk,
	input wire logic srst,
	input wire logic raw,
	input wire logic rise_en,
	input wire logic [6:0] rise_cnt,
	input wire logic fall_en,
	input wire logic [6:0] fall_cnt,
	output logic flag
);
	localparam int PW = $clog2(STEP_CYCLES);
	logic busy;
	logic [PW-1:0] pre;
	logic [6:0] steps;
	logic edge_en;
	logic [6:0] edge_cnt;

	// Pick the timer setting of the edge under way
	assign edge_en = raw ? rise_en : fall_en;
	assign edge_cnt = raw ? rise_cnt : fall_cnt;

	// Hold old level for count steps, then follow
	always_ff @(posedge clk) begin
		if (srst) begin
			flag <= FLAG_RST;
			busy <= 1'b0;
			pre <= '0;
			steps <= '0;
		end else if (!busy) begin
			if (raw != flag) begin
				if (edge_en && edge_cnt != 7'h00) begin
					busy <= 1'b1; // [R21] [R24]
					steps <= edge_cnt;
					pre <= '0;
				end else begin
					flag <= raw;
				end
			end
		end else if (pre == PW'(STEP_CYCLES - 1)) begin
			pre <= '0; // [R22]
			if (steps == 7'h01) begin
				busy <= 1'b0;
				flag <= raw; // [R24]
			end else begin
				steps <= steps - 7'h01;
			end
		end else begin
			pre <= pre + PW'(1);
		end
	end
endmodule : tws_mask

//--- hdl/tws_dev.sv
// Purpose: Slave end: two-wire register access and configuration outputs.
// Assumes: SCL and SDA come from another domain and are synchronised here.
// Notes: Outputs are registered and decoded from the configuration set; SIGNAL_LOST_FLAG comes from the mask timer.
//
// Chosen here: registers reached over the two-wire bus; the APB interface sits on the master.
`timescale 1ns/100ps
module tws_dev import tws_pkg::*; #(parameter int STEP_CYCLES = MASK_STEP_CYC) (
	input wire logic CLK,
	input wire logic SRST,
	tws_if.dev BUS,
	input wire logic RAW_LOSS,
	output logic OFFSET_CANCEL_OFF,
	output logic [7:0] THRESHOLD_SHIFT_CODE,
	output logic THRESHOLD_ADJ_ON,
	output logic [1:0] CROSSING_SPAN_SELECT,
	output logic [3:0] DEEMPHASIS_CODE,
	output logic [2:0] OUTPUT_SWING_CODE,
	output logic OUTPUT_INVERT,
	output logic SIGNAL_LOST_RANGE,
	output logic RECEIVER_OPT_ON,
	output logic [1:0] RECEIVER_EQUALIZE_CODE,
	output logic INPUT_BIAS_BOOST,
	output logic [6:0] SIGNAL_LOST_LEVEL,
	output logic SIGNAL_LOST_FLAG
);
	typedef enum logic [8:0] {
		S_IDLE = 9'h001,
		S_ADDR = 9'h002,
		S_AACK = 9'h004,
		S_INDEX = 9'h008,
		S_IACK = 9'h010,
		S_WDATA = 9'h020,
		S_WACK = 9'h040,
		S_RDATA = 9'h080,
		S_SKIP = 9'h100
	} tws_dstate_t;

	tws_dstate_t state;
	logic [1:0] scl_s;
	logic [1:0] sda_s;
	logic [1:0] loss_s;
	logic scl_q;
	logic sda_q;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic [7:0] shreg;
	logic [3:0] bitcnt;
	logic rw;
	logic [7:0] index;
	logic [7:0] cfg [0:15];
	logic [7:0] rd_byte;
	logic [6:0] level_eff;
	logic wr_strobe;

	// Registers that exist at the index
	function automatic logic reg_mapped(input logic [7:0] idx);
		reg_mapped = (idx == IDX_CTRL) || (idx == IDX_THRESH) || (idx == IDX_RANGE_DE)
			|| (idx == IDX_SWING) || (idx == IDX_RECEIVER_EQUALIZE_CODE) || (idx == IDX_LEVEL)
			|| (idx == IDX_FALL_MASK) || (idx == IDX_RISE_MASK);
	endfunction : reg_mapped

	// Two flops per line; edge logic compares the second with a third delayed copy
	always_ff @(posedge CLK) begin
		if (SRST) begin
			scl_s <= 2'h3;
			sda_s <= 2'h3;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			loss_s <= {FLAG_RST, FLAG_RST};
		end else begin
			scl_s <= {scl_s[0], BUS.scl};
			sda_s <= {sda_s[0], BUS.sda};
			scl_q <= scl_s[1];
			sda_q <= sda_s[1];
			loss_s <= {loss_s[0], RAW_LOSS};
		end
	end

	assign scl_rise = scl_s[1] & ~scl_q;
	assign scl_fall = ~scl_s[1] & scl_q;
	assign start_det = scl_s[1] & scl_q & sda_q & ~sda_s[1]; // [R04]
	assign stop_det = scl_s[1] & scl_q & ~sda_q & sda_s[1]; // [R05]
	assign wr_strobe = scl_fall && state == S_WDATA && bitcnt == 4'h8;
	assign level_eff = cfg[IDX_LEVEL[3:0]][BIT_SELECT] ? cfg[IDX_LEVEL[3:0]][6:0] : LEVEL_DEFAULT; // [R20]

	// Read-back mux; unmapped indices read zero
	always_comb begin
		rd_byte = 8'h00;
		if (index == IDX_LEVEL_RO)
			rd_byte = {1'b0, level_eff}; // [R11]
		else if (reg_mapped(index))
			rd_byte = cfg[index[3:0]];
	end

	// Protocol sequencer; data changes only after SCL falls
	always_ff @(posedge CLK) begin
		if (SRST) begin
			state <= S_IDLE;
			bitcnt <= 4'h0;
			shreg <= 8'h00;
			rw <= 1'b0;
			index <= 8'h00;
			BUS.d_sda_oe <= 1'b0;
		end else if (start_det) begin
			state <= S_ADDR; // [R06]
			bitcnt <= 4'h0;
			BUS.d_sda_oe <= 1'b0;
		end else if (stop_det) begin
			state <= S_IDLE;
			BUS.d_sda_oe <= 1'b0;
		end else if (scl_rise && (state == S_ADDR || state == S_INDEX || state == S_WDATA)) begin
			shreg <= {shreg[6:0], sda_s[1]};
			bitcnt <= bitcnt + 4'h1;
		end else if (scl_fall) begin
			unique case (state)
				S_ADDR: begin
					if (bitcnt == 4'h8) begin
						bitcnt <= 4'h0;
						if (shreg[7:1] == SLAVE_ADDR) begin
							BUS.d_sda_oe <= 1'b1; // [R01] [R07]
							rw <= shreg[0];
							state <= S_AACK;
						end else begin
							state <= S_SKIP; // [R08]
						end
					end
				end
				S_AACK: begin
					if (rw) begin
						BUS.d_sda_oe <= ~rd_byte[7]; // [R23]
						shreg <= {rd_byte[6:0], 1'b0};
						bitcnt <= 4'h1;
						state <= S_RDATA;
					end else begin
						BUS.d_sda_oe <= 1'b0;
						state <= S_INDEX; // [R02]
					end
				end
				S_INDEX: begin
					if (bitcnt == 4'h8) begin
						index <= shreg;
						bitcnt <= 4'h0;
						BUS.d_sda_oe <= 1'b1; // [R07]
						state <= S_IACK;
					end
				end
				S_IACK: begin
					BUS.d_sda_oe <= 1'b0;
					state <= S_WDATA;
				end
				S_WDATA: begin
					if (bitcnt == 4'h8) begin
						bitcnt <= 4'h0;
						BUS.d_sda_oe <= 1'b1; // [R07]
						state <= S_WACK;
					end
				end
				S_WACK: begin
					// Further bytes fall into the released slot
					BUS.d_sda_oe <= 1'b0;
					state <= S_SKIP; // [R03] [R09]
				end
				S_RDATA: begin
					if (bitcnt == 4'h8) begin
						BUS.d_sda_oe <= 1'b0; // Master answers NACK here
						state <= S_SKIP;
					end else begin
						BUS.d_sda_oe <= ~shreg[7];
						shreg <= {shreg[6:0], 1'b0};
						bitcnt <= bitcnt + 4'h1;
					end
				end
				S_IDLE, S_SKIP: begin
					BUS.d_sda_oe <= 1'b0; // [R10]
				end
			endcase
		end
	end

	// Open drain: the data value is always low
	always_ff @(posedge CLK) begin
		BUS.d_sda_o <= 1'b0;
	end

	// Register file; write lands as the data byte ends
	always_ff @(posedge CLK) begin
		if (SRST) begin
			for (int i = 0; i < 16; i++)
				cfg[i] <= (i == int'(IDX_SWING)) ? SWING_RST : REG_RST; // [R16]
		end else if (wr_strobe && reg_mapped(index)) begin
			cfg[index[3:0]] <= shreg; // [R11]
		end
	end

	// Configuration outputs, registered for clean pins
	always_ff @(posedge CLK) begin
		if (SRST) begin
			OFFSET_CANCEL_OFF <= 1'b0;
			THRESHOLD_SHIFT_CODE <= 8'h00;
			THRESHOLD_ADJ_ON <= 1'b0;
			CROSSING_SPAN_SELECT <= 2'h0;
			DEEMPHASIS_CODE <= 4'h0;
			OUTPUT_SWING_CODE <= SWING_RST[2:0];
			OUTPUT_INVERT <= 1'b0;
			SIGNAL_LOST_RANGE <= 1'b0;
			RECEIVER_OPT_ON <= 1'b0;
			RECEIVER_EQUALIZE_CODE <= RXEQ_DEFAULT;
			INPUT_BIAS_BOOST <= 1'b0;
			SIGNAL_LOST_LEVEL <= LEVEL_DEFAULT;
		end else begin
			OFFSET_CANCEL_OFF <= cfg[IDX_CTRL[3:0]][BIT_OC_OFF]; // [R12]
			OUTPUT_INVERT <= cfg[IDX_CTRL[3:0]][BIT_INVERT]; // [R18]
			SIGNAL_LOST_RANGE <= cfg[IDX_CTRL[3:0]][BIT_LOST_RANGE]; // [R19]
			THRESHOLD_SHIFT_CODE <= cfg[IDX_THRESH[3:0]];
			THRESHOLD_ADJ_ON <= |cfg[IDX_THRESH[3:0]]; // [R13]
			CROSSING_SPAN_SELECT <= cfg[IDX_RANGE_DE[3:0]][5:4]; // [R13]
			// Codes above the top step clamp to it
			if (cfg[IDX_RANGE_DE[3:0]][3:0] > 4'(MAX_DEEMPH))
				DEEMPHASIS_CODE <= 4'(MAX_DEEMPH); // [R17]
			else
				DEEMPHASIS_CODE <= cfg[IDX_RANGE_DE[3:0]][3:0]; // [R17]
			OUTPUT_SWING_CODE <= cfg[IDX_SWING[3:0]][2:0]; // [R16]
			RECEIVER_OPT_ON <= cfg[IDX_RECEIVER_EQUALIZE_CODE[3:0]][BIT_SELECT]; // [R14]
			if (cfg[IDX_RECEIVER_EQUALIZE_CODE[3:0]][BIT_SELECT]) begin
				RECEIVER_EQUALIZE_CODE <= cfg[IDX_RECEIVER_EQUALIZE_CODE[3:0]][3:2]; // [R14]
				INPUT_BIAS_BOOST <= cfg[IDX_RECEIVER_EQUALIZE_CODE[3:0]][BIT_BIAS];
			end else begin
				RECEIVER_EQUALIZE_CODE <= RXEQ_DEFAULT;
				INPUT_BIAS_BOOST <= 1'b0;
			end
			SIGNAL_LOST_LEVEL <= level_eff; // [R20]
		end
	end

	// Masking of the synchronised loss detector
	tws_mask #(.STEP_CYCLES(STEP_CYCLES)) u_mask (
		.clk(CLK),
		.srst(SRST),
		.raw(loss_s[1]),
		.rise_en(cfg[IDX_RISE_MASK[3:0]][BIT_SELECT]),
		.rise_cnt(cfg[IDX_RISE_MASK[3:0]][6:0]),
		.fall_en(cfg[IDX_FALL_MASK[3:0]][BIT_SELECT]),
		.fall_cnt(cfg[IDX_FALL_MASK[3:0]][6:0]),
		.flag(SIGNAL_LOST_FLAG) // [R21]
	);
endmodule : tws_dev

//--- hdl/tws_host.sv
// Purpose: Master end: APB command registers driving two-wire transfers.
// Assumes: Slave never stretches the clock, so SCL is not read back.
// Notes: One bit takes four quarters of QTR_CYCLES cycles each.
`timescale 1ns/100ps
module tws_host import tws_pkg::*; #(parameter int QTR_CYCLES = QTR_CYC) (
	input wire logic CLK,
	input wire logic SRST,
	tws_if.host BUS,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR
);
	typedef enum logic [1:0] {H_IDLE = 2'h1, H_RUN = 2'h2} tws_hstate_t;
	localparam logic [1:0] K_START = 2'h0;
	localparam logic [1:0] K_BYTE = 2'h1;
	localparam logic [1:0] K_STOP = 2'h2;

	tws_hstate_t state;
	logic [1:0] sda_s;
	logic [7:0] qcnt;
	logic [1:0] phase;
	logic [3:0] bitn;
	logic [2:0] step;
	logic [1:0] kind;
	logic [8:0] sh;
	logic rd;
	logic [7:0] idx;
	logic [7:0] wdat;
	logic [7:0] rdat;
	logic nack;
	logic tick;
	logic apb_wr;
	logic [2:0] stop_step;
	logic [10:0] next_item;

	// Transfer script: kind and nine bits (data plus ack slot)
	function automatic logic [10:0] host_item(input logic [2:0] s, input logic r,
		input logic [7:0] i, input logic [7:0] d);
		host_item = {K_STOP, 9'h1ff};
		unique case (s)
			3'h0: host_item = {K_START, 9'h1ff};
			3'h1: host_item = {K_BYTE, SLAVE_ADDR, 1'b0, 1'b1}; // [R01]
			3'h2: host_item = {K_BYTE, i, 1'b1};
			3'h3: host_item = r ? {K_START, 9'h1ff} : {K_BYTE, d, 1'b1}; // [R23]
			3'h4: host_item = r ? {K_BYTE, SLAVE_ADDR, 1'b1, 1'b1} : {K_STOP, 9'h1ff};
			3'h5: host_item = {K_BYTE, 9'h1ff}; // Read byte, NACK
			default: host_item = {K_STOP, 9'h1ff};
		endcase
	endfunction : host_item

	assign tick = qcnt == 8'(QTR_CYCLES - 1);
	assign stop_step = rd ? 3'h6 : 3'h4;
	assign apb_wr = PSEL & PENABLE & PREADY & PWRITE & (PADDR == OFS_CMD);
	assign next_item = host_item(step + 3'h1, rd, idx, wdat);

	// Data line synchroniser
	always_ff @(posedge CLK) begin
		if (SRST)
			sda_s <= 2'h3;
		else
			sda_s <= {sda_s[0], BUS.sda};
	end

	// APB slave, one wait state per access
	always_ff @(posedge CLK) begin
		if (SRST) begin
			PREADY <= 1'b0;
			PRDATA <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end else begin
			PREADY <= PSEL & PENABLE & ~PREADY;
			if (PSEL & PENABLE & ~PREADY) begin
				PSLVERR <= (PADDR != OFS_CMD) && (PADDR != OFS_STATUS);
				if (!PWRITE && PADDR == OFS_STATUS)
					PRDATA <= {16'h0000, rdat, 6'h00, nack, state == H_RUN};
				else
					PRDATA <= 32'h0000_0000;
			end
		end
	end

	// Bit engine; a command written while busy is dropped
	always_ff @(posedge CLK) begin
		if (SRST) begin
			state <= H_IDLE;
			qcnt <= 8'h00;
			phase <= 2'h0;
			bitn <= 4'h0;
			step <= 3'h0;
			kind <= K_STOP;
			sh <= 9'h1ff;
			rd <= 1'b0;
			idx <= 8'h00;
			wdat <= 8'h00;
			rdat <= 8'h00;
			nack <= 1'b0;
			BUS.m_scl_oe <= 1'b0;
			BUS.m_sda_oe <= 1'b0;
		end else if (state == H_IDLE) begin
			if (apb_wr) begin
				rd <= PWDATA[0];
				idx <= PWDATA[15:8];
				wdat <= PWDATA[23:16];
				nack <= 1'b0;
				step <= 3'h0;
				{kind, sh} <= {K_START, 9'h1ff};
				qcnt <= 8'h00;
				phase <= 2'h0;
				bitn <= 4'h0;
				state <= H_RUN; // [R10]
			end
		end else if (!tick) begin
			qcnt <= qcnt + 8'h01;
		end else begin
			qcnt <= 8'h00;
			phase <= phase + 2'h1;
			unique case (kind)
				K_START: begin
					unique case (phase)
						2'h0: BUS.m_sda_oe <= 1'b0;
						2'h1: BUS.m_scl_oe <= 1'b0;
						2'h2: BUS.m_sda_oe <= 1'b1; // [R04] [R06]
						2'h3: begin
							BUS.m_scl_oe <= 1'b1;
							step <= step + 3'h1;
							{kind, sh} <= next_item;
						end
					endcase
				end
				K_BYTE: begin
					unique case (phase)
						2'h0: BUS.m_sda_oe <= ~sh[8];
						2'h1: BUS.m_scl_oe <= 1'b0;
						2'h2: sh <= {sh[7:0], sda_s[1]};
						2'h3: begin
							BUS.m_scl_oe <= 1'b1;
							bitn <= bitn + 4'h1;
							if (bitn == 4'h8) begin
								bitn <= 4'h0;
								if (rd && step == 3'h5)
									rdat <= sh[8:1];
								if (sh[0] && !(rd && step == 3'h5)) begin
									nack <= 1'b1; // [R08] [R09]
									step <= stop_step;
									{kind, sh} <= {K_STOP, 9'h1ff};
								end else begin
									step <= step + 3'h1; // [R02] [R03]
									{kind, sh} <= next_item;
								end
							end
						end
					endcase
				end
				K_STOP: begin
					unique case (phase)
						2'h0: BUS.m_sda_oe <= 1'b1;
						2'h1: BUS.m_scl_oe <= 1'b0;
						2'h2: BUS.m_sda_oe <= 1'b0; // [R05]
						2'h3: state <= H_IDLE;
					endcase
				end
				default: state <= H_IDLE;
			endcase
		end
	end

	// Open drain: driven value is always low
	always_ff @(posedge CLK) begin
		BUS.m_scl_o <= 1'b0;
		BUS.m_sda_o <= 1'b0;
	end
endmodule : tws_host

//--- tb/tws_monitor.sv
// Purpose: Wire-level checks on the two-wire link between master and slave.
// Assumes: One clock domain; SRST synchronous, active high.
// Notes: Sees only the interface signals, so slave internals stay hidden.
`timescale 1ns/100ps
module tws_monitor (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic scl,
	input wire logic sda,
	input wire logic m_scl_oe,
	input wire logic m_sda_oe,
	input wire logic d_sda_oe
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SRST);
	// Bus conditions on the resolved wires
	sequence s_start;
		scl && $past(scl) && $fell(sda);
	endsequence
	sequence s_stop;
		scl && $past(scl) && $rose(sda);
	endsequence
	property p_high_min;
		$rose(scl) |-> scl [*8];
	endproperty
	a_high_min: assert property (p_high_min) else $error("clock high phase too short");
	property p_low_min;
		$fell(scl) |-> !scl [*8];
	endproperty
	a_low_min: assert property (p_low_min) else $error("clock low phase too short");
	// Slave moving SDA while SCL is high would fake a START or STOP
	property p_dev_stable_high;
		scl && $past(scl) |-> $stable(d_sda_oe);
	endproperty
	a_dev_stable_high: assert property (p_dev_stable_high) else $error("slave moved data with clock high");
	property p_dev_after_fall;
		$rose(d_sda_oe) |-> !scl && $past(scl, 8);
	endproperty
	a_dev_after_fall: assert property (p_dev_after_fall) else $error("slave drive not just after clock fall");
	property p_ack_held;
		$rose(scl) && d_sda_oe |-> d_sda_oe [*8];
	endproperty
	a_ack_held: assert property (p_ack_held) else $error("acknowledge not held");
	property p_start_quiet;
		s_start |-> !d_sda_oe [*8];
	endproperty
	a_start_quiet: assert property (p_start_quiet) else $error("slave drove data after start");
	property p_stop_quiet;
		s_stop |-> !d_sda_oe [*8];
	endproperty
	a_stop_quiet: assert property (p_stop_quiet) else $error("slave drove data after stop");
	// Overlap while the clock is low is harmless on open drain
	property p_one_driver;
		d_sda_oe && scl |-> !m_sda_oe;
	endproperty
	a_one_driver: assert property (p_one_driver) else $error("transmitter did not release data");
	property p_idle_after_reset;
		$fell(SRST) |-> scl && sda && !d_sda_oe && !m_scl_oe;
	endproperty
	a_idle_after_reset: assert property (p_idle_after_reset) else $error("bus not idle after reset");
endmodule : tws_monitor

//--- tb/tb_top.sv
// Purpose: Drives the master over APB and checks the slave's configuration outputs.
// Assumes: Both ends share one 200 MHz clock; mask step 8 cycles, bit quarter 24 cycles.
// Notes: Shortened link timing leaves room for the 13 transfers.
`timescale 1ns/100ps
module tb_top import tws_pkg::*; ;
	logic clk;
	logic srst = 1'b1;
	logic raw = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr, oc_off, th_on, inv, rng, opt_on, bias, flag;
	logic [7:0] th_code;
	logic [1:0] span, eq;
	logic [3:0] deemph;
	logic [2:0] swing;
	logic [6:0] level;
	logic [31:0] rd, rnd;
	logic [7:0] v;
	logic err;
	int failures = 0;
	int checks = 0;
	integer seed = 32'h91dbd445;
	tws_if i_tws_if ();
	tws_dev #(.STEP_CYCLES(8)) i_tws_dev (.CLK(clk), .SRST(srst), .BUS(i_tws_if.dev), .RAW_LOSS(raw),
		.OFFSET_CANCEL_OFF(oc_off), .THRESHOLD_SHIFT_CODE(th_code), .THRESHOLD_ADJ_ON(th_on),
		.CROSSING_SPAN_SELECT(span), .DEEMPHASIS_CODE(deemph), .OUTPUT_SWING_CODE(swing),
		.OUTPUT_INVERT(inv), .SIGNAL_LOST_RANGE(rng), .RECEIVER_OPT_ON(opt_on),
		.RECEIVER_EQUALIZE_CODE(eq), .INPUT_BIAS_BOOST(bias), .SIGNAL_LOST_LEVEL(level), .SIGNAL_LOST_FLAG(flag));
	tws_host #(.QTR_CYCLES(24)) i_tws_host (.CLK(clk), .SRST(srst), .BUS(i_tws_if.host), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
	tws_monitor i_tws_monitor (.CLK(clk), .SRST(srst), .scl(i_tws_if.scl), .sda(i_tws_if.sda),
		.m_scl_oe(i_tws_if.m_scl_oe), .m_sda_oe(i_tws_if.m_sda_oe), .d_sda_oe(i_tws_if.d_sda_oe));
	// Free-running system clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic end_of_test;
		if (failures == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Expected span and de-emphasis; codes above the top step clamp to it
	function automatic logic [7:0] exp_range(input logic [7:0] r);
		exp_range = {2'h0, r[5:4], (r[3:0] > 4'(MAX_DEEMPH)) ? 4'(MAX_DEEMPH) : r[3:0]};
	endfunction : exp_range
	// One APB transfer; request held until PREADY is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Wait states are the slave's choice; only the watchdog ends a hang
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Launch a link transfer and poll status until the master goes idle
	task automatic xfer(input logic r, input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, OFS_CMD, {8'h00, d, idx, 7'h00, r});
		do begin
			apb(1'b0, OFS_STATUS, 32'h0000_0000);
		end while (rd[0] !== 1'b0);
		chk({7'h00, rd[1]}, 8'h00);
	endtask : xfer
	// About 2.8k cycles per write, 3.7k per read; limit leaves slack over the 13 used
	initial begin
		repeat (60000) @(posedge clk);
		failures++;
		end_of_test();
	end
	initial begin
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		chk({5'h00, swing}, 8'h02);
		chk({7'h00, th_on}, 8'h00);
		chk({1'b0, level}, {1'b0, LEVEL_DEFAULT});
		chk({7'h00, flag}, {7'h00, FLAG_RST});
		// Unmapped APB offset must be refused
		apb(1'b0, 8'h08, 32'h0000_0000);
		chk({7'h00, err}, 8'h01);
		// Falling edge without mask passes straight through
		raw <= 1'b0;
		repeat (6) @(posedge clk);
		chk({7'h00, flag}, 8'h00);
		rnd = $random(seed);
		v = rnd[7:0];
		xfer(1'b0, IDX_CTRL, v);
		chk({5'h00, inv, rng, oc_off}, {5'h00, v[4], v[2], v[1]});
		xfer(1'b1, IDX_CTRL, 8'h00);
		chk(rd[15:8] & 8'h16, v & 8'h16);
		xfer(1'b0, IDX_RECEIVER_EQUALIZE_CODE, 8'h85);
		chk({4'h0, opt_on, eq, bias}, 8'h0b);
		// Rising mask of two steps holds the flag for 16 cycles
		xfer(1'b0, IDX_RISE_MASK, 8'h82);
		raw <= 1'b1;
		repeat (10) @(posedge clk);
		chk({7'h00, flag}, 8'h00);
		repeat (20) @(posedge clk);
		chk({7'h00, flag}, 8'h01);
		rnd = $random(seed);
		v = {1'b1, rnd[6:0]};
		xfer(1'b0, IDX_LEVEL, v);
		chk({1'b0, level}, {1'b0, v[6:0]});
		xfer(1'b1, IDX_LEVEL_RO, 8'h00);
		chk(rd[15:8], {1'b0, v[6:0]});
		// Unmapped index reads back zero
		xfer(1'b1, 8'h05, 8'h00);
		chk(rd[15:8], 8'h00);
		rnd = $random(seed);
		v = rnd[7:0] | 8'h01;
		xfer(1'b0, IDX_THRESH, v);
		chk(th_code, v);
		chk({7'h00, th_on}, 8'h01);
		xfer(1'b0, IDX_THRESH, 8'h00);
		chk({7'h00, th_on}, 8'h00);
		rnd = $random(seed);
		v = rnd[7:0];
		xfer(1'b0, IDX_RANGE_DE, v);
		chk({2'h0, span, deemph}, exp_range(v));
		xfer(1'b0, IDX_RANGE_DE, 8'h2f);
		chk({2'h0, span, deemph}, exp_range(8'h2f));
		// Select clear: stored settings must not reach the receiver
		xfer(1'b0, IDX_RECEIVER_EQUALIZE_CODE, 8'h0d);
		chk({4'h0, opt_on, eq, bias}, {5'h00, RXEQ_DEFAULT, 1'b0});
		// Falling mask of one step holds the flag for 8 cycles
		xfer(1'b0, IDX_FALL_MASK, 8'h81);
		raw <= 1'b0;
		repeat (6) @(posedge clk);
		chk({7'h00, flag}, 8'h01);
		repeat (14) @(posedge clk);
		chk({7'h00, flag}, 8'h00);
		end_of_test();
	end
endmodule : tb_top
